// file: src/sfr_pkg.sv
// Purpose: shared constants for the synthesizer word and symbol-rate registers
// Assumes: 8-bit register port, byte-wide registers
// Notes: offsets are the byte addresses of the serial register map
package sfr_pkg;
  localparam logic [7:0] SFR_OFF_WORD_HIGH = 8'h0D;
  localparam logic [7:0] SFR_OFF_WORD_MID = 8'h0E;
  localparam logic [7:0] SFR_OFF_WORD_LOW = 8'h0F;
  localparam logic [7:0] SFR_OFF_RATE_EXP = 8'h10;
  localparam logic [7:0] SFR_OFF_RATE_MANT = 8'h11;
  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [1:0] SFR_WORD_TOP_FIXED = 2'h1;
  localparam logic [5:0] SFR_RST_WORD_HIGH = 6'h1E;
  localparam logic [7:0] SFR_RST_WORD_MID = 8'hC4;
  localparam logic [7:0] SFR_RST_WORD_LOW = 8'hEC;
  localparam logic [3:0] SFR_RST_RATE_EXP = 4'hC;
  localparam logic [7:0] SFR_RST_RATE_MANT = 8'h22;
  localparam logic [3:0] SFR_RATE_EXP_RSVD = 4'h0;
  ////////////////////////////////////////////////////////////////////////////////
  localparam int SFR_WORD_FRAC_BITS = 16;
  localparam int SFR_RATE_FRAC_BITS = 28;
  localparam logic [8:0] SFR_MANT_HIDDEN = 9'h100;
endpackage : sfr_pkg

// file: src/sfr_reg_if.sv
// Purpose: carrier between the register decoder and the field store
// Assumes: one clock, writes and reads one byte per cycle
// Notes: fields leave the store as registered values
`timescale 1ns/1ps
interface sfr_reg_if;
  logic wr_high;
  logic wr_mid;
  logic wr_low;
  logic wr_exp;
  logic wr_mant;
  logic [7:0] wdata;
  logic [7:0] rd_sel;
  logic [7:0] rdata;
  logic [5:0] word_high;
  logic [7:0] word_mid;
  logic [7:0] word_low;
  logic [3:0] rate_exp;
  logic [7:0] rate_mant;
  modport ctrl (output wr_high, wr_mid, wr_low, wr_exp, wr_mant, wdata, rd_sel,
    input rdata, word_high, word_mid, word_low, rate_exp, rate_mant);
  modport store (input wr_high, wr_mid, wr_low, wr_exp, wr_mant, wdata, rd_sel,
    output rdata, word_high, word_mid, word_low, rate_exp, rate_mant);
endinterface : sfr_reg_if

// file: src/sfr_store.sv
// Purpose: field storage and registered read data
// Assumes: strobes are one-hot, rd_sel is already decoded to a byte image
// Notes: only writable bits are stored; fixed bits are supplied by the decoder
`timescale 1ns/1ps
module sfr_store
  import sfr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  sfr_reg_if.store bus
);
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      bus.word_high <= SFR_RST_WORD_HIGH;
      bus.word_mid <= SFR_RST_WORD_MID;
      bus.word_low <= SFR_RST_WORD_LOW;
      bus.rate_exp <= SFR_RST_RATE_EXP;
      bus.rate_mant <= SFR_RST_RATE_MANT;
      bus.rdata <= 8'h00;
    end else begin
      if (bus.wr_high) bus.word_high <= bus.wdata[5:0];
      if (bus.wr_mid) bus.word_mid <= bus.wdata;
      if (bus.wr_low) bus.word_low <= bus.wdata;
      if (bus.wr_exp) bus.rate_exp <= bus.wdata[3:0];
      if (bus.wr_mant) bus.rate_mant <= bus.wdata;
      bus.rdata <= bus.rd_sel;
    end
  end
endmodule : sfr_store

// file: src/sfr_regs.sv
// Purpose: synthesizer base-frequency word and symbol-rate registers
// Assumes: crystal frequency, channel number and spacing given in Hz / units
// Notes: derived frequencies are truncated integer Hz and bit/s
`timescale 1ns/1ps
module sfr_regs
  import sfr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] crystal_frequency_in,
  input wire logic [7:0] channel_number_in,
  input wire logic [31:0] channel_spacing_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [23:0] synth_word_out,
  output logic [3:0] rate_exponent_out,
  output logic [8:0] rate_mantissa_out,
  output logic [31:0] base_synth_word_out,
  output logic [31:0] carrier_synth_word_out,
  output logic [31:0] data_rate_out
);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  sfr_reg_if bus ();

  sfr_store sfr_store_inst (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .bus(bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic sel_high = hit(reg_addr_in, SFR_OFF_WORD_HIGH);
  wire logic sel_mid = hit(reg_addr_in, SFR_OFF_WORD_MID);
  wire logic sel_low = hit(reg_addr_in, SFR_OFF_WORD_LOW);
  wire logic sel_exp = hit(reg_addr_in, SFR_OFF_RATE_EXP);
  wire logic sel_mant = hit(reg_addr_in, SFR_OFF_RATE_MANT);
  wire logic sel_any = sel_high | sel_mid | sel_low | sel_exp | sel_mant;
  wire logic [7:0] img_high = {SFR_WORD_TOP_FIXED, bus.word_high};
  wire logic [7:0] img_exp = {SFR_RATE_EXP_RSVD, bus.rate_exp};
  wire logic [23:0] word = {img_high, bus.word_mid, bus.word_low};
  // the hidden one is added here, never stored, so software cannot clear it
  wire logic [8:0] mant9 = SFR_MANT_HIDDEN | {1'b0, bus.rate_mant};

  assign bus.wdata = reg_wdata_in;
  assign bus.wr_high = reg_wr_in & sel_high;
  assign bus.wr_mid = reg_wr_in & sel_mid;
  assign bus.wr_low = reg_wr_in & sel_low;
  assign bus.wr_exp = reg_wr_in & sel_exp;
  assign bus.wr_mant = reg_wr_in & sel_mant;
  // unmapped addresses read zero
  assign bus.rd_sel = ({8{sel_high}} & img_high) | ({8{sel_mid}} & bus.word_mid)
    | ({8{sel_low}} & bus.word_low) | ({8{sel_exp}} & img_exp)
    | ({8{sel_mant}} & bus.rate_mant);

  ////////////////////////////////////////////////////////////////////////////////
  // derived frequencies; 64-bit products avoid overflow before the shift
  wire logic [63:0] base_prod = 64'(crystal_frequency_in) * 64'(word);
  wire logic [31:0] next_base = 32'(base_prod >> SFR_WORD_FRAC_BITS);
  wire logic [63:0] rate_prod = (64'(crystal_frequency_in) * 64'(mant9)) << bus.rate_exp;
  wire logic [31:0] next_rate = 32'(rate_prod >> SFR_RATE_FRAC_BITS);
  wire logic [31:0] next_carrier =
    32'(base_prod >> SFR_WORD_FRAC_BITS) + 32'(channel_number_in) * channel_spacing_in;
  logic read_pending;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
      read_pending <= 1'b0;
      synth_word_out <= 24'h000000;
      rate_exponent_out <= 4'h0;
      rate_mantissa_out <= 9'h000;
      base_synth_word_out <= 32'h00000000;
      carrier_synth_word_out <= 32'h00000000;
      data_rate_out <= 32'h00000000;
    end else begin
      reg_rdata_out <= bus.rdata;
      read_pending <= reg_rd_in;
      // valid waits one more edge so it lines up with the store's registered data
      reg_rvalid_out <= read_pending;
      synth_word_out <= word;
      rate_exponent_out <= bus.rate_exp;
      rate_mantissa_out <= mant9;
      base_synth_word_out <= next_base;
      carrier_synth_word_out <= next_carrier;
      data_rate_out <= next_rate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  logic past_valid;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) past_valid <= 1'b0;
    else past_valid <= 1'b1;
  end

  top_bits_fixed_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    past_valid |-> synth_word_out[23:22] == SFR_WORD_TOP_FIXED)
    else $error("top frequency word bits not 01");
  high_read_image_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_rd_in && sel_high |-> ##2 reg_rvalid_out && reg_rdata_out[7:6] == 2'h1)
    else $error("high register read lost fixed bits");
  high_write_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_wr_in && sel_high |-> ##2 synth_word_out[21:16] == $past(reg_wdata_in[5:0], 2))
    else $error("high register write lost");
  word_assembly_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_wr_in && sel_mid ##1 !reg_wr_in |=>
    synth_word_out[15:8] == $past(reg_wdata_in, 2))
    else $error("middle byte not in word bits 15:8");
  low_write_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_wr_in && sel_low |-> ##2 synth_word_out[7:0] == $past(reg_wdata_in, 2))
    else $error("low byte not in word bits 7:0");
  mid_read_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_rd_in && sel_mid |-> ##2 reg_rdata_out == $past(synth_word_out[15:8]))
    else $error("middle byte read mismatch");
  low_read_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_rd_in && sel_low |-> ##2 reg_rdata_out == $past(synth_word_out[7:0]))
    else $error("low byte read mismatch");
  low_kept_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    !(reg_wr_in && sel_low) |-> ##2 synth_word_out[7:0] == $past(synth_word_out[7:0]))
    else $error("low byte changed without a write");
  base_formula_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    past_valid |-> base_synth_word_out ==
    32'((64'($past(crystal_frequency_in)) * 64'(synth_word_out)) >> SFR_WORD_FRAC_BITS))
    else $error("base frequency mismatch");
  exp_reserved_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_rd_in && sel_exp |-> ##2 reg_rdata_out[7:4] == 4'h0)
    else $error("reserved exponent bits not zero");
  exp_write_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_wr_in && sel_exp |-> ##2 rate_exponent_out == $past(reg_wdata_in[3:0], 2))
    else $error("exponent write lost");
  exp_read_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_rd_in && sel_exp |-> ##2 reg_rdata_out[3:0] == $past(rate_exponent_out))
    else $error("exponent read mismatch");
  exp_kept_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    !(reg_wr_in && sel_exp) |-> ##2 rate_exponent_out == $past(rate_exponent_out))
    else $error("exponent changed without a write");
  mant_write_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_wr_in && sel_mant |-> ##2 rate_mantissa_out[7:0] == $past(reg_wdata_in, 2))
    else $error("mantissa write lost");
  mant_read_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_rd_in && sel_mant |-> ##2 reg_rdata_out == $past(rate_mantissa_out[7:0]))
    else $error("mantissa read mismatch");
  hidden_one_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    past_valid |-> rate_mantissa_out[8])
    else $error("hidden mantissa bit missing");
  rate_formula_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    past_valid |-> data_rate_out == 32'(((64'($past(crystal_frequency_in))
    * 64'(rate_mantissa_out)) << rate_exponent_out) >> SFR_RATE_FRAC_BITS))
    else $error("data rate mismatch");
  carrier_sum_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    past_valid |-> carrier_synth_word_out == base_synth_word_out
    + 32'($past(channel_number_in)) * $past(channel_spacing_in))
    else $error("carrier mismatch");
  reset_defaults_a: assert property (
    @(posedge clock_in)
    !rst_n_in ##1 rst_n_in |=> synth_word_out == 24'h5EC4EC
    && rate_exponent_out == 4'hC && rate_mantissa_out == 9'h122)
    else $error("reset defaults wrong");
  reset_idle_a: assert property (
    @(posedge clock_in)
    !rst_n_in |=> !reg_rvalid_out && base_synth_word_out == 32'h00000000)
    else $error("outputs not cleared in reset");
  rd_valid_pulse_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_rd_in |-> ##2 reg_rvalid_out)
    else $error("read valid missing two edges after request");
  rd_valid_quiet_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    !reg_rd_in |-> ##2 !reg_rvalid_out)
    else $error("read valid without a request");
  unmapped_read_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    reg_rd_in && !sel_any |-> ##2 reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");

  write_high_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    reg_wr_in && sel_high);
  read_mant_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    reg_rd_in && sel_mant);
  max_exp_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    rate_exponent_out == 4'hF);
  unmapped_read_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    reg_rd_in && !sel_any);
  top_ones_write_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    reg_wr_in && sel_high && reg_wdata_in[7:6] != SFR_WORD_TOP_FIXED);
endmodule : sfr_regs

// file: tb/sfr_host_model.sv
// Purpose: host side of the serial register port
// Assumes: one strobe per request, changed just after the falling edge
// Notes: released write data and read address carry the inverse of the last value so stale data never looks good
`timescale 1ns/1ps
module sfr_host_model (
  input wire logic clock_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_rvalid_in,
  output logic [7:0] reg_addr_out = 8'h00,
  output logic [7:0] reg_wdata_out = 8'h00,
  output logic reg_wr_out = 1'b0,
  output logic reg_rd_out = 1'b0
);
  bit keep_range = 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, inout logic [7:0] d);
    if (keep_range && a == 8'h0D) d = 8'd85 + (d % 8'd11);
    @(negedge clock_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clock_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
  endtask : wr
  // ok drops when no valid pulse comes within a few cycles
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int n;
    @(negedge clock_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge clock_in);
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    n = 0;
    while (reg_rvalid_in !== 1'b1 && n < 8) begin
      @(negedge clock_in);
      n++;
    end
    ok = (n < 8);
    d = reg_rdata_in;
  endtask : rd
endmodule : sfr_host_model

// file: tb/synth_synth_word_symbol_rate_regs_bench.sv
// Purpose: self-checking bench for the synthesizer word and symbol-rate registers
// Assumes: reads answer within a few cycles, outputs settle two edges after a write
// Notes: the model keeps read images as bytes and derives outputs with 64-bit math
`timescale 1ns/1ps
module synth_synth_word_symbol_rate_regs_bench;
  import sfr_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [31:0] xtal = 32'd26000000;
  logic [7:0] ch = 8'h00;
  logic [31:0] sp = 32'h00030D40;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, rvalid;
  logic [23:0] word;
  logic [3:0] expo;
  logic [8:0] mant;
  logic [31:0] base, carrier, rate;
  logic [7:0] mdl [5];
  int failures = 0;
  int comparisons = 0;
  int seed = 81637;
  always #10 clock_in = ~clock_in;
  sfr_regs sfr_regs_inst (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .crystal_frequency_in(xtal),
    .channel_number_in(ch), .channel_spacing_in(sp), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .synth_word_out(word), .rate_exponent_out(expo),
    .rate_mantissa_out(mant), .base_synth_word_out(base), .carrier_synth_word_out(carrier),
    .data_rate_out(rate));
  sfr_host_model sfr_host_model_inst (.clock_in(clock_in), .reg_rdata_in(rdata),
    .reg_rvalid_in(rvalid), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr),
    .reg_rd_out(rd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic do_reset();
    @(negedge clock_in);
    rst_n_in = 1'b0;
    repeat (16) @(negedge clock_in);
    rst_n_in = 1'b1;
    mdl = '{8'h5E, 8'hC4, 8'hEC, 8'h0C, 8'h22};
    repeat (2) @(negedge clock_in);
  endtask : do_reset
  task automatic check_outs();
    logic [63:0] w, b, r;
    w = {mdl[0], mdl[1], mdl[2]};
    b = (64'(xtal) * w) >> 16;
    r = ((64'(xtal) * (64'd256 + mdl[4])) << mdl[3][3:0]) >> 28;
    chk(word, w, "word");
    chk(expo, mdl[3][3:0], "exponent");
    chk(mant, {1'b1, mdl[4]}, "mantissa");
    chk(base, b[31:0], "base");
    chk(rate, r[31:0], "rate");
    chk(carrier, 32'(b[31:0] + ch * sp), "carrier");
  endtask : check_outs
  task automatic read_all();
    logic [7:0] q;
    bit ok;
    for (int a = 8'h0D; a <= 8'h12; a++) begin
      sfr_host_model_inst.rd(8'(a), q, ok);
      if (!ok) begin
        failures++;
        tally_and_finish();
      end
      chk(q, (a < 8'h12) ? mdl[a - 8'h0D] : 8'h00, "read");
    end
  endtask : read_all
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] a, d;
    do_reset();
    read_all();
    check_outs();
    for (int i = 0; i < 40; i++) begin
      a = 8'h0D + 8'($random(seed) & 7);
      d = 8'($random(seed));
      // second half ignores the host range so the fixed top bits see ones
      sfr_host_model_inst.keep_range = (i < 20);
      sfr_host_model_inst.wr(a, d);
      if (a == 8'h0D) mdl[0] = {2'b01, d[5:0]};
      else if (a == 8'h10) mdl[3] = {4'h0, d[3:0]};
      else if (a < 8'h12) mdl[a - 8'h0D] = d;
      xtal = 32'd26000000 + 32'($random(seed) & 20'hFFFFF);
      ch = 8'($random(seed));
      sp = 32'($random(seed) & 20'hFFFFF);
      repeat (2) @(negedge clock_in);
      check_outs();
      read_all();
      if (i == 30) begin
        do_reset();
        check_outs();
      end
    end
    tally_and_finish();
  end
endmodule : synth_synth_word_symbol_rate_regs_bench
